// file: bench/dpbc_partner.sv
// host dma side model: acknowledges each request after a set delay
`timescale 1ns/10ps
module dpbc_partner
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic host_dma_request,
   input wire logic [3:0] delay,
   output logic host_dma_ack,
   output int handshakes
);
   int wait_cnt;
   ////////////////////////////////////////////////////////////////////////////////
   // ack rises after delay, falls only once the request has gone
   always @(negedge clk)
   begin
      if (!rst_n)
      begin
         host_dma_ack <= 1'b0;
         wait_cnt <= 0;
         handshakes <= 0;
      end
      else if (host_dma_request && !host_dma_ack)
      begin
         wait_cnt <= wait_cnt + 1;
         if (wait_cnt >= int'(delay))
         begin
            host_dma_ack <= 1'b1;
            handshakes <= handshakes + 1;
         end
      end
      else if (!host_dma_request && host_dma_ack)
      begin
         host_dma_ack <= 1'b0;
         wait_cnt <= 0;
      end
   end
endmodule

// file: bench/dpbc_properties.sv
// concurrent checks on the port behaviour of the buffer controller
`timescale 1ns/10ps
module dpbc_properties
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic ale,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [7:0] ad_in,
   input wire logic [7:0] ad_out,
   input wire logic ad_oe,
   input wire logic periph_req,
   input wire logic [7:0] buf_addr,
   input wire logic memory_select,
   input wire logic buffer_write_strobe,
   input wire logic host_page_strobe,
   input wire logic device_page_strobe,
   input wire logic host_receive_enable,
   input wire logic host_drive_enable,
   input wire logic host_latch_strobe,
   input wire logic host_dma_request,
   input wire logic host_dma_ack
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////////////
   // buffer ram strobes
   a_write_in_select: assert property (buffer_write_strobe |-> memory_select)
      else $error("write strobe without memory select");
   a_write_one_cycle: assert property (buffer_write_strobe |=> !buffer_write_strobe)
      else $error("write strobe longer than one cycle");
   a_periph_gets_access: assert property ($rose(periph_req) |-> ##[1:6] memory_select)
      else $error("peripheral request not served in time");
   ////////////////////////////////////////////////////////////////////////////////
   // host handshake, latch control, page strobes and read data drive
   a_req_held_ack: assert property ($fell(host_dma_request) |-> $past(host_dma_ack))
      else $error("host request dropped before acknowledge");
   a_req_has_enable: assert property (host_dma_request
      |-> host_drive_enable || host_receive_enable)
      else $error("host request without bus enable");
   a_latch_before_drive: assert property ($rose(host_drive_enable)
      |-> host_latch_strobe || $past(host_latch_strobe))
      else $error("drive enable without latch strobe");
   a_latch_one_cycle: assert property (host_latch_strobe |=> !host_latch_strobe)
      else $error("latch strobe longer than one cycle");
   a_page_one_cycle: assert property ((host_page_strobe || device_page_strobe)
      |=> !(host_page_strobe || device_page_strobe))
      else $error("page strobe longer than one cycle");
   a_read_drive_oe: assert property ($rose(ad_oe) |-> !rd_n && !$past(rd_n, 2))
      else $error("read data driven without read strobe");
   // main scenarios reached
   c_host_req: cover property ($rose(host_dma_request));
   c_ram_write: cover property (buffer_write_strobe);
   c_dev_page: cover property (device_page_strobe);
endmodule

bind dpbc_top dpbc_properties u_props
(
   .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
   .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe), .periph_req(periph_req),
   .buf_addr(buf_addr), .memory_select(memory_select),
   .buffer_write_strobe(buffer_write_strobe), .host_page_strobe(host_page_strobe),
   .device_page_strobe(device_page_strobe), .host_receive_enable(host_receive_enable),
   .host_drive_enable(host_drive_enable), .host_latch_strobe(host_latch_strobe),
   .host_dma_request(host_dma_request), .host_dma_ack(host_dma_ack)
);

// file: bench/dpbc_top_tb.sv
// self-checking bench for the buffer controller
`timescale 1ns/10ps
module dpbc_top_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cs_n = 1'b1;
   logic ale = 1'b0;
   logic rd_n = 1'b1;
   logic wr_n = 1'b1;
   logic [7:0] ad_in = 8'h00;
   logic periph_req = 1'b0;
   logic [3:0] delay = 4'h0;
   logic [7:0] ad_out, buf_addr, last_addr;
   logic ad_oe, memory_select, buffer_write_strobe, host_page_strobe, device_page_strobe;
   logic host_receive_enable, host_drive_enable, host_latch_strobe, host_dma_request;
   logic host_dma_ack;
   int handshakes, base, num_errors, total_checks, ms_cnt, ws_cnt, pg_cnt, rcv_cnt, lat_cnt;
   int drv_cnt, hp_cnt, oe_cnt;
   // 100 MHz clock
   always #5 clk = ~clk;
   dpbc_top dut
   (
      .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
      .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe), .periph_req(periph_req),
      .buf_addr(buf_addr), .memory_select(memory_select),
      .buffer_write_strobe(buffer_write_strobe), .host_page_strobe(host_page_strobe),
      .device_page_strobe(device_page_strobe), .host_receive_enable(host_receive_enable),
      .host_drive_enable(host_drive_enable), .host_latch_strobe(host_latch_strobe),
      .host_dma_request(host_dma_request), .host_dma_ack(host_dma_ack)
   );
   dpbc_partner host
   (
      .clk(clk), .rst_n(rst_n), .host_dma_request(host_dma_request), .delay(delay),
      .host_dma_ack(host_dma_ack), .handshakes(handshakes)
   );
   // port activity counters
   always @(posedge clk)
   begin
      if (memory_select === 1'b1)
      begin
         ms_cnt++;
         last_addr = buf_addr;
         if (buffer_write_strobe === 1'b1)
            ws_cnt++;
      end
      if (device_page_strobe === 1'b1)
         pg_cnt++;
      if (host_page_strobe === 1'b1)
         hp_cnt++;
      if (ad_oe === 1'b1)
         oe_cnt++;
      if (host_receive_enable === 1'b1)
         rcv_cnt++;
      if (host_latch_strobe === 1'b1)
         lat_cnt++;
      if (host_drive_enable === 1'b1)
         drv_cnt++;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // shared tasks
   task automatic test_done;
      begin
         if (num_errors == 0 && total_checks > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      begin
         total_checks++;
         if (seen !== exp)
         begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task automatic clr;
      begin
         ms_cnt = 0;
         ws_cnt = 0;
         pg_cnt = 0;
         rcv_cnt = 0;
         lat_cnt = 0;
         drv_cnt = 0;
         hp_cnt = 0;
         oe_cnt = 0;
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic wr,
      output logic [7:0] q);
      begin
         cs_n = 1'b0;
         ale = 1'b1;
         ad_in = a;
         repeat (4) @(negedge clk);
         ale = 1'b0;
         ad_in = d;
         wr_n = !wr;
         rd_n = wr;
         repeat (6) @(negedge clk);
         q = ad_out;
         wr_n = 1'b1;
         rd_n = 1'b1;
         cs_n = 1'b1;
         repeat (4) @(negedge clk);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      begin
         bus(a, d, 1'b1, q);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] q;
      begin
         bus(a, 8'h00, 1'b0, q);
         check(q, exp);
      end
   endtask
   task automatic pbyte;
      begin
         periph_req = 1'b1;
         repeat (3) @(negedge clk);
         periph_req = 1'b0;
         repeat (6) @(negedge clk);
      end
   endtask
   task automatic wait_done;
      logic [7:0] q;
      int n;
      begin
         q = 8'h00;
         n = 0;
         while (q[5] !== 1'b1 && n < 60)
         begin
            bus(8'h53, 8'h00, 1'b0, q);
            n++;
         end
         if (q[5] !== 1'b1)
         begin
            num_errors++;
            test_done;
         end
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_regs;
      begin
         for (int i = 0; i < 6; i++)
            wr(8'h5a + 8'(i), i[0] ? 8'h03 : 8'ha0 + 8'(i));
         for (int i = 0; i < 6; i++)
            rdc(8'h5a + 8'(i), i[0] ? 8'h03 : 8'ha0 + 8'(i));
         wr(8'h59, 8'h00);
         for (int i = 0; i < 6; i++)
            rdc(8'h5a + 8'(i), 8'h00);
         wr(8'h5b, 8'h00);
         wr(8'h5d, 8'h00);
      end
   endtask
   task automatic t_periph;
      begin
         wr(8'h53, 8'h10);
         wr(8'h5c, 8'hff);
         wr(8'h5d, 8'h03);
         clr;
         pbyte;
         check(last_addr, 8'hff);
         check(8'(ws_cnt), 8'h01);
         check(8'(pg_cnt != 0), 8'h01);
         check(8'(hp_cnt), 8'h00);
         rdc(8'h5d, 8'h00);
         rdc(8'h5c, 8'h00);
         repeat (3) pbyte;
         check(8'(ws_cnt), 8'h04);
         check(last_addr, 8'h02);
         rdc(8'h5c, 8'h03);
         wr(8'h53, 8'h00);
         wr(8'h5a, 8'h07);
         clr;
         pbyte;
         check(8'(ms_cnt), 8'h01);
         check(8'(ws_cnt), 8'h00);
         check(last_addr, 8'h07);
      end
   endtask
   task automatic t_host_rd;
      begin
         wr(8'h53, 8'h10);
         wr(8'h5a, 8'h00);
         rdc(8'h5c, 8'h03);
         wr(8'h5e, 8'h02);
         wr(8'h5f, 8'h00);
         base = handshakes;
         delay = 4'h0;
         wr(8'h53, 8'h18);
         wait_done;
         rdc(8'h5a, 8'h02);
         check(8'(handshakes - base), 8'h02);
         wr(8'h5e, 8'h03);
         wait_done;
         rdc(8'h5a, 8'h03);
         check(8'(handshakes - base), 8'h03);
      end
   endtask
   task automatic t_host_wr;
      begin
         wr(8'h53, 8'h00);
         wr(8'h5c, 8'h00);
         wr(8'h5e, 8'h02);
         rdc(8'h53, 8'h00);
         delay = 4'h5;
         clr;
         wr(8'h53, 8'h04);
         wait_done;
         rdc(8'h5c, 8'h02);
         check(8'(ws_cnt), 8'h02);
         check(8'(rcv_cnt != 0), 8'h01);
         wr(8'h53, 8'h00);
      end
   endtask
   task automatic t_latch;
      logic [7:0] q;
      begin
         wr(8'h52, 8'h04);
         clr;
         bus(8'h50, 8'h00, 1'b0, q);
         check(8'(rcv_cnt != 0), 8'h01);
         check(8'(oe_cnt), 8'h00);
         wr(8'h52, 8'h08);
         clr;
         wr(8'h50, 8'h5a);
         check(8'(lat_cnt), 8'h01);
         check(8'(drv_cnt != 0), 8'h01);
         wr(8'h52, 8'h00);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      clr;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      wr(8'h59, 8'h00);
      rdc(8'h52, 8'h00);
      rdc(8'h53, 8'h00);
      rdc(8'h60, 8'h00);
      wr(8'h54, 8'h03);
      t_regs;
      t_periph;
      t_host_rd;
      t_host_wr;
      t_latch;
      test_done;
   end
endmodule

// file: core/dpbc_page.sv
// page strobe sequencer for the external high-order address registers
`timescale 1ns/10ps
module dpbc_page
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic host_req,
   input wire logic dev_req,
   input wire logic busy,
   output logic active,
   output logic host_sel,
   output logic strobe
);
   ////////////////////////////////////////////////////////////////////////////////
   // pending flags: set wins over clear so no page change is lost
   logic host_pend;
   logic dev_pend;
   logic phase;
   logic start;
   assign start = !busy && !active && (host_pend || dev_pend);
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         host_pend <= 1'b0;
         dev_pend <= 1'b0;
         active <= 1'b0;
         host_sel <= 1'b0;
         phase <= 1'b0;
         strobe <= 1'b0;
      end
      else
      begin
         host_pend <= host_req || (host_pend && !(start && host_pend));
         dev_pend <= dev_req || (dev_pend && !(start && !host_pend));
         if (start)
         begin
            active <= 1'b1; // high byte goes out on the address lines first
            host_sel <= host_pend;
            phase <= 1'b0;
         end
         else if (active && !phase && !busy)
         begin
            phase <= 1'b1;
            strobe <= 1'b1;
         end
         else if (active && phase)
         begin
            active <= 1'b0;
            strobe <= 1'b0;
         end
      end
   end
endmodule

// file: core/dpbc_ptr.sv
// one 16-bit buffer pointer with byte writes, clear, increment and masked rollover
`timescale 1ns/10ps
module dpbc_ptr
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic wr_lo,
   input wire logic wr_hi,
   input wire logic [7:0] wdata,
   input wire logic incr,
   input wire logic [7:0] size,
   output logic [15:0] value,
   output logic hi_changed
);
   ////////////////////////////////////////////////////////////////////////////////
   // incremented value with high bits beyond the buffer size forced back to zero
   logic [15:0] plus_one;
   logic [15:0] wrapped;
   logic [15:0] next_value;
   assign plus_one = value + 16'h0001;
   assign wrapped = {plus_one[15:8] & size, plus_one[7:0]};
   assign next_value = clear ? dpbc_pkg::PTR_RESET
      : wr_lo ? {value[15:8], wdata}
      : wr_hi ? {wdata, value[7:0]}
      : incr ? wrapped
      : value;

   // pointer register and high-byte change pulse
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         value <= dpbc_pkg::PTR_RESET;
         hi_changed <= 1'b0;
      end
      else
      begin
         value <= next_value;
         hi_changed <= wr_hi || (next_value[15:8] != value[15:8]);
      end
   end
endmodule

// file: core/dpbc_top.sv
// dual-port circular buffer controller: registers, peripheral port, host dma port
// Overview of operation
// - sample peripheral request, access RAM next cycle
// - one byte per peripheral request
// - direction set: write RAM at write pointer
// - direction clear: read RAM at read pointer
// - host read: read, latch, drive, request, acknowledge
// - host write: receive host data, write RAM
// - host never passes the stop pointer
// - pointer equals stop: halt, set done
// - new stop write clears done, resumes
// - reset register write clears all pointers
// - size register sets rollover point
// - write pointer per byte, read per peripheral byte or host handshake
// - block write: write latch starts handshakes
// - latch read asserts receive enable when enabled
// - latch write strobes then drives host bus
// - pointers are 16 bits, two bytes each
// - peripheral wins over host and page updates
// - new high byte out, then page strobe
`timescale 1ns/10ps
module dpbc_top
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic ale,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [7:0] ad_in,
   output logic [7:0] ad_out,
   output logic ad_oe,
   input wire logic periph_req,
   output logic [7:0] buf_addr,
   output logic memory_select,
   output logic buffer_write_strobe,
   output logic host_page_strobe,
   output logic device_page_strobe,
   output logic host_receive_enable,
   output logic host_drive_enable,
   output logic host_latch_strobe,
   output logic host_dma_request,
   input wire logic host_dma_ack
);
   ////////////////////////////////////////////////////////////////////////////////
   // input synchronisers: first stage read only by the second
   logic [5:0] sync1, sync2;
   logic [7:0] ad_s1, ad_s2;
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         sync1 <= 6'h00;
         sync2 <= 6'h00;
         ad_s1 <= 8'h00;
         ad_s2 <= 8'h00;
      end
      else
      begin
         sync1 <= {!cs_n, ale, !rd_n, !wr_n, periph_req, host_dma_ack};
         sync2 <= sync1;
         ad_s1 <= ad_in;
         ad_s2 <= ad_s1;
      end
   end
   logic cs_s, ale_s, rd_s, wr_s, preq_s, ack_s;
   assign {cs_s, ale_s, rd_s, wr_s, preq_s, ack_s} = sync2;

   ////////////////////////////////////////////////////////////////////////////////
   // processor bus: address latch, write edge detection and read level decode
   logic [7:0] reg_addr;
   logic wr_d, rd_d;
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         reg_addr <= 8'h00;
         wr_d <= 1'b0;
         rd_d <= 1'b0;
      end
      else
      begin
         if (ale_s)
            reg_addr <= ad_s2;
         wr_d <= wr_s && cs_s;
         rd_d <= rd_s && cs_s;
      end
   end
   wire wr_pulse = wr_s && cs_s && !wr_d;
   wire rd_active = rd_s && cs_s;

   // write decode
   wire wr_hic = wr_pulse && (reg_addr == dpbc_pkg::ADDR_HOST_CTRL);
   wire wr_dma = wr_pulse && (reg_addr == dpbc_pkg::ADDR_DMA_CTRL);
   wire wr_size = wr_pulse && (reg_addr == dpbc_pkg::ADDR_BUF_SIZE);
   wire wr_rst = wr_pulse && (reg_addr == dpbc_pkg::ADDR_RESET_CTRL);
   wire wr_rp_lo = wr_pulse && (reg_addr == dpbc_pkg::ADDR_RD_PTR_LO);
   wire wr_rp_hi = wr_pulse && (reg_addr == dpbc_pkg::ADDR_RD_PTR_HI);
   wire wr_wp_lo = wr_pulse && (reg_addr == dpbc_pkg::ADDR_WR_PTR_LO);
   wire wr_wp_hi = wr_pulse && (reg_addr == dpbc_pkg::ADDR_WR_PTR_HI);
   wire wr_sp_lo = wr_pulse && (reg_addr == dpbc_pkg::ADDR_STOP_LO);
   wire wr_sp_hi = wr_pulse && (reg_addr == dpbc_pkg::ADDR_STOP_HI);
   wire wr_latch = wr_pulse && (reg_addr == dpbc_pkg::ADDR_HOST_LATCH);

   ////////////////////////////////////////////////////////////////////////////////
   // control registers
   logic [7:0] host_ctrl, dma_ctrl, buf_size;
   logic chip_reset, done, done_set;
   wire ptr_clear = wr_rst || chip_reset;
   wire dir_in = dma_ctrl[dpbc_pkg::DMA_DIR_BIT];
   wire rd_latch_on = dma_ctrl[dpbc_pkg::DMA_READ_LATCH_BIT];
   wire wr_latch_on = dma_ctrl[dpbc_pkg::DMA_WRITE_LATCH_BIT];
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         host_ctrl <= dpbc_pkg::HOST_CTRL_RESET;
         dma_ctrl <= dpbc_pkg::DMA_CTRL_RESET;
         buf_size <= dpbc_pkg::BUF_SIZE_RESET;
         chip_reset <= dpbc_pkg::RESET_CTRL_RESET;
         done <= 1'b0;
      end
      else
      begin
         if (wr_rst)
            chip_reset <= ad_s2[dpbc_pkg::RST_CHIP_BIT];
         if (chip_reset && !wr_rst)
         begin
            host_ctrl <= dpbc_pkg::HOST_CTRL_RESET;
            dma_ctrl <= dpbc_pkg::DMA_CTRL_RESET;
            buf_size <= dpbc_pkg::BUF_SIZE_RESET;
         end
         else
         begin
            if (wr_hic)
               host_ctrl <= ad_s2;
            if (wr_dma)
               dma_ctrl <= ad_s2;
            if (wr_size)
               buf_size <= ad_s2;
         end
         // set wins over the clear by a new stop pointer
         if (done_set)
            done <= 1'b1;
         else if (wr_sp_lo || wr_sp_hi || chip_reset)
            done <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pointers
   logic [15:0] rd_ptr, wr_ptr, stop_ptr;
   logic rd_incr, wr_incr, rd_hi_chg, wr_hi_chg;
   dpbc_ptr u_rd_ptr (.clk(clk), .rst_n(rst_n), .clear(ptr_clear), .wr_lo(wr_rp_lo),
      .wr_hi(wr_rp_hi), .wdata(ad_s2), .incr(rd_incr), .size(buf_size), .value(rd_ptr),
      .hi_changed(rd_hi_chg));
   dpbc_ptr u_wr_ptr (.clk(clk), .rst_n(rst_n), .clear(ptr_clear), .wr_lo(wr_wp_lo),
      .wr_hi(wr_wp_hi), .wdata(ad_s2), .incr(wr_incr), .size(buf_size), .value(wr_ptr),
      .hi_changed(wr_hi_chg));
   dpbc_ptr u_stop_ptr (.clk(clk), .rst_n(rst_n), .clear(ptr_clear), .wr_lo(wr_sp_lo),
      .wr_hi(wr_sp_hi), .wdata(ad_s2), .incr(1'b0), .size(buf_size), .value(stop_ptr),
      .hi_changed());

   ////////////////////////////////////////////////////////////////////////////////
   // peripheral port: request sampled once, access in the following cycle
   logic preq_d, periph_cycle;
   wire preq_edge = preq_s && !preq_d;
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         preq_d <= 1'b0;
         periph_cycle <= 1'b0;
      end
      else
      begin
         preq_d <= preq_s;
         periph_cycle <= preq_edge;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // host dma state machine
   typedef enum logic [5:0] {
      DPBC_IDLE = 6'b00_0001,
      DPBC_RD_MEM = 6'b00_0010,
      DPBC_RD_REQ = 6'b00_0100,
      DPBC_WR_REQ = 6'b00_1000,
      DPBC_WR_MEM = 6'b01_0000,
      DPBC_WAIT = 6'b10_0000
   } dpbc_state_t;
   dpbc_state_t state, next_state;
   wire [15:0] host_ptr = dir_in ? rd_ptr : wr_ptr;
   // high comparator bits gated by buffer size
   wire at_stop = (host_ptr[7:0] == stop_ptr[7:0])
      && ((host_ptr[15:8] & buf_size) == (stop_ptr[15:8] & buf_size));
   wire host_go = !done && !at_stop && !chip_reset
      && ((dir_in && rd_latch_on) || (!dir_in && wr_latch_on));
   assign done_set = (state == DPBC_IDLE) && !done && at_stop
      && ((dir_in && rd_latch_on) || (!dir_in && wr_latch_on));
   logic page_busy;
   always_comb
   begin
      next_state = state;
      case (state)
         DPBC_IDLE:
            if (host_go && !periph_cycle && !preq_edge && !page_busy)
               next_state = dir_in ? DPBC_RD_MEM : DPBC_WR_REQ;
         DPBC_RD_MEM:
            next_state = DPBC_RD_REQ;
         DPBC_RD_REQ:
            if (ack_s)
               next_state = DPBC_WAIT;
         DPBC_WR_REQ:
            if (ack_s)
               next_state = DPBC_WR_MEM;
         DPBC_WR_MEM:
            if (!periph_cycle)
               next_state = DPBC_WAIT;
         DPBC_WAIT:
            if (!ack_s)
               next_state = DPBC_IDLE;
         default:
            next_state = DPBC_IDLE;
      endcase
   end
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         state <= DPBC_IDLE;
      else
         state <= next_state;
   end
   // write pointer per byte stored, read pointer per byte the peripheral reads or per completed host handshake
   assign wr_incr = (periph_cycle && dir_in)
      || (state == DPBC_WR_MEM && !periph_cycle);
   assign rd_incr = (periph_cycle && !dir_in)
      || (state == DPBC_RD_REQ && ack_s);

   ////////////////////////////////////////////////////////////////////////////////
   // page updates of the external high-order registers
   logic page_active, page_host, page_strobe;
   assign page_busy = periph_cycle || preq_edge || (state != DPBC_IDLE);
   dpbc_page u_page (.clk(clk), .rst_n(rst_n), .host_req(dir_in ? rd_hi_chg : wr_hi_chg),
      .dev_req(dir_in ? wr_hi_chg : rd_hi_chg), .busy(page_busy), .active(page_active),
      .host_sel(page_host), .strobe(page_strobe));
   wire [15:0] page_ptr = (page_host == dir_in) ? rd_ptr : wr_ptr;

   ////////////////////////////////////////////////////////////////////////////////
   // ram address and strobes
   wire host_mem = (state == DPBC_RD_MEM) || (state == DPBC_WR_MEM && !periph_cycle);
   wire [15:0] mem_ptr = periph_cycle ? (dir_in ? wr_ptr : rd_ptr) : host_ptr;
   wire next_ms = periph_cycle || host_mem;
   wire next_we = (periph_cycle && dir_in)
      || (!periph_cycle && state == DPBC_WR_MEM);
   wire [7:0] next_addr = (page_active && !next_ms) ? page_ptr[15:8] : mem_ptr[7:0];
   // external latch port strobes
   wire latch_rd = rd_active && (reg_addr == dpbc_pkg::ADDR_HOST_LATCH)
      && host_ctrl[dpbc_pkg::HIC_RECV_BIT];
   wire latch_wr = wr_latch && host_ctrl[dpbc_pkg::HIC_DRIVE_BIT];
   logic latch_drive;
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         latch_drive <= 1'b0;
      else if (latch_wr)
         latch_drive <= 1'b1;
      else if (wr_hic && !ad_s2[dpbc_pkg::HIC_DRIVE_BIT])
         latch_drive <= 1'b0;
   end

   // registered outputs
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         buf_addr <= 8'h00;
         memory_select <= 1'b0;
         buffer_write_strobe <= 1'b0;
         host_page_strobe <= 1'b0;
         device_page_strobe <= 1'b0;
         host_latch_strobe <= 1'b0;
         host_drive_enable <= 1'b0;
         host_receive_enable <= 1'b0;
         host_dma_request <= 1'b0;
      end
      else
      begin
         buf_addr <= next_addr;
         memory_select <= next_ms;
         buffer_write_strobe <= next_we;
         host_page_strobe <= page_strobe && page_host;
         device_page_strobe <= page_strobe && !page_host;
         host_latch_strobe <= (state == DPBC_RD_MEM) || latch_wr;
         host_drive_enable <= (next_state == DPBC_RD_REQ) || latch_drive;
         host_receive_enable <= (next_state == DPBC_WR_REQ)
            || (state == DPBC_WR_MEM) || latch_rd;
         host_dma_request <= (next_state == DPBC_RD_REQ) || (next_state == DPBC_WR_REQ);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register read back
   wire [7:0] dma_read = {dma_ctrl[7:6], done, dma_ctrl[4:0]};
   wire [7:0] next_rdata = (reg_addr == dpbc_pkg::ADDR_HOST_CTRL) ? host_ctrl
      : (reg_addr == dpbc_pkg::ADDR_DMA_CTRL) ? dma_read
      : (reg_addr == dpbc_pkg::ADDR_RD_PTR_LO) ? rd_ptr[7:0]
      : (reg_addr == dpbc_pkg::ADDR_RD_PTR_HI) ? rd_ptr[15:8]
      : (reg_addr == dpbc_pkg::ADDR_WR_PTR_LO) ? wr_ptr[7:0]
      : (reg_addr == dpbc_pkg::ADDR_WR_PTR_HI) ? wr_ptr[15:8]
      : (reg_addr == dpbc_pkg::ADDR_STOP_LO) ? stop_ptr[7:0]
      : (reg_addr == dpbc_pkg::ADDR_STOP_HI) ? stop_ptr[15:8]
      : 8'h00;
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ad_out <= 8'h00;
         ad_oe <= 1'b0;
      end
      else
      begin
         ad_out <= next_rdata;
         ad_oe <= rd_active && (reg_addr != dpbc_pkg::ADDR_HOST_LATCH); // latch drives bus
      end
   end
endmodule

// file: include/dpbc_pkg.sv
// package of register offsets, field positions and reset values for the buffer controller
package dpbc_pkg;
   // register addresses on the multiplexed processor bus
   localparam logic [7:0] ADDR_HOST_LATCH = 8'h50;
   localparam logic [7:0] ADDR_HOST_CTRL = 8'h52;
   localparam logic [7:0] ADDR_DMA_CTRL = 8'h53;
   localparam logic [7:0] ADDR_BUF_SIZE = 8'h54;
   localparam logic [7:0] ADDR_RESET_CTRL = 8'h59;
   localparam logic [7:0] ADDR_RD_PTR_LO = 8'h5a;
   localparam logic [7:0] ADDR_RD_PTR_HI = 8'h5b;
   localparam logic [7:0] ADDR_WR_PTR_LO = 8'h5c;
   localparam logic [7:0] ADDR_WR_PTR_HI = 8'h5d;
   localparam logic [7:0] ADDR_STOP_LO = 8'h5e;
   localparam logic [7:0] ADDR_STOP_HI = 8'h5f;
   // field positions
   localparam int HIC_RECV_BIT = 2;
   localparam int HIC_DRIVE_BIT = 3;
   localparam int DMA_WRITE_LATCH_BIT = 2;
   localparam int DMA_READ_LATCH_BIT = 3;
   localparam int DMA_DIR_BIT = 4;
   localparam int DMA_DONE_BIT = 5;
   localparam int RST_CHIP_BIT = 0;
   // reset values
   localparam logic [7:0] HOST_CTRL_RESET = 8'h00;
   localparam logic [7:0] DMA_CTRL_RESET = 8'h00;
   localparam logic [7:0] BUF_SIZE_RESET = 8'h00;
   localparam logic [15:0] PTR_RESET = 16'h0000;
   localparam logic RESET_CTRL_RESET = 1'b1;
endpackage
